//--- bench/isa_i2c_master_model.sv
`timescale 1ns/1ps
// ============================================================
// bus master, open drain: a pull of 1 drags the line low
module isa_i2c_master_model (
  input  wire logic sys_clk,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclPull,
  output logic      sdaPull
);
  localparam int PH = 4;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk
  // the slave may still hold scl low, so the high phase starts only once it lets go
  task automatic rel_scl();
    sclPull <= 1'b0;
    do @(posedge sys_clk); while (sclLine !== 1'b1);
    wait_clk(PH);
  endtask : rel_scl
  task automatic send_start();
    sdaPull <= 1'b0;
    wait_clk(PH);
    rel_scl();
    sdaPull <= 1'b1;
    wait_clk(PH);
    sclPull <= 1'b1;
    wait_clk(PH);
  endtask : send_start
  task automatic send_stop();
    sdaPull <= 1'b1;
    wait_clk(PH);
    rel_scl();
    sdaPull <= 1'b0;
    wait_clk(PH);
  endtask : send_stop
  // nine bits msb first; a 1 releases sda, each bit is read back at the end of high
  task automatic xfer(input logic [8:0] v, output logic [8:0] got);
    for (int i = 8; i >= 0; i--) begin
      sdaPull <= ~v[i];
      wait_clk(PH);
      rel_scl();
      got[i] = sdaLine;
      sclPull <= 1'b1;
    end
    wait_clk(PH);
  endtask : xfer
endmodule : isa_i2c_master_model

//--- bench/isa_i2c_slave_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin numErrors++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module isa_i2c_slave_bench
  import isa_pkg::*;
;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic sclOut, sclOe, sdaOut, sdaOe, pinsOpenDrain, portIrq, rerr;
  logic sclLine, sdaLine, mScl, mSda;
  logic [8:0] got;
  int numErrors;
  int checkCount;
  // pull-ups: a released line reads high
  assign sclLine = ~(sclOe | mScl);
  assign sdaLine = ~(sdaOe | mSda);
  isa_i2c_slave i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .pinsOpenDrain(pinsOpenDrain), .portIrq(portIrq)
  );
  isa_i2c_master_model i_mst (
    .sys_clk(sys_clk), .sclLine(sclLine), .sdaLine(sdaLine), .sclPull(mScl), .sdaPull(mSda)
  );
  always #5 sys_clk = ~sys_clk;
  // ============================================================
  // apb master; two idle edges after each transfer let registered outputs settle
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    `CHK($sformatf("reg %h", a), {24'h000000, e}, rdata & {24'h000000, m})
  endtask : rd_chk
  // ============================================================
  // scenarios
  task automatic t_reset();
    rd_chk(ADDR_IRQ_FLAGS, 8'hff, 8'h02);
    rd_chk(ADDR_IRQ_EN, 8'hff, 8'h00);
    rd_chk(ADDR_CTRL, 8'hff, 8'h00);
    rd_chk(ADDR_STATUS, 8'hff, 8'h00);
    rd_chk(12'h3fc, 8'hff, 8'h00);
    `CHK("slverr", 1'b1, rerr)
  endtask : t_reset
  task automatic t_rx7();
    wr(ADDR_IRQ_EN, 8'h80);
    wr(ADDR_OWN, 8'ha4);
    wr(ADDR_CTRL, {4'h2, MODE_SLV7});
    `CHK("opendrain", 1'b1, pinsOpenDrain)
    i_mst.send_start();
    i_mst.xfer({8'ha4, 1'b1}, got);
    `CHK("ack", 1'b0, got[0])
    rd_chk(ADDR_STATUS, 8'h3f, 8'h09);
    `CHK("irq", 1'b1, portIrq)
    rd_chk(ADDR_BUFFER, 8'hff, 8'ha4);
    rd_chk(ADDR_STATUS, 8'h01, 8'h00);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    `CHK("irq", 1'b0, portIrq)
    i_mst.xfer({8'h3c, 1'b1}, got);
    `CHK("ack", 1'b0, got[0])
    rd_chk(ADDR_STATUS, 8'h21, 8'h21);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    i_mst.xfer({8'h55, 1'b1}, got);
    `CHK("ack", 1'b1, got[0])
    rd_chk(ADDR_IRQ_FLAGS, 8'h80, 8'h80);
    rd_chk(ADDR_BUFFER, 8'hff, 8'h3c);
    rd_chk(ADDR_CTRL, 8'h40, 8'h40);
    i_mst.xfer({8'h66, 1'b1}, got);
    `CHK("ack", 1'b1, got[0])
    rd_chk(ADDR_BUFFER, 8'hff, 8'h3c);
    wr(ADDR_CTRL, {4'h2, MODE_SLV7});
    rd_chk(ADDR_CTRL, 8'h40, 8'h00);
    i_mst.send_stop();
    rd_chk(ADDR_STATUS, 8'h10, 8'h10);
  endtask : t_rx7
  task automatic t_reject();
    i_mst.send_start();
    i_mst.xfer({8'ha6, 1'b1}, got);
    `CHK("ack", 1'b1, got[0])
    i_mst.send_stop();
    wr(ADDR_CTRL, {4'h0, MODE_SLV7});
    `CHK("opendrain", 1'b0, pinsOpenDrain)
    i_mst.send_start();
    i_mst.xfer({8'ha4, 1'b1}, got);
    `CHK("ack", 1'b1, got[0])
    i_mst.send_stop();
  endtask : t_reject
  task automatic t_rx10();
    wr(ADDR_OWN, 8'hf2);
    wr(ADDR_CTRL, {4'h2, MODE_SLV10});
    i_mst.send_start();
    i_mst.xfer({8'hf2, 1'b1}, got);
    `CHK("ack", 1'b0, got[0])
    rd_chk(ADDR_STATUS, 8'h03, 8'h03);
    `CHK("stretch", 1'b1, sclOe)
    rd_chk(ADDR_BUFFER, 8'hff, 8'hf2);
    wr(ADDR_OWN, 8'h5a);
    `CHK("stretch", 1'b0, sclOe)
    i_mst.xfer({8'h5a, 1'b1}, got);
    `CHK("ack", 1'b0, got[0])
    rd_chk(ADDR_STATUS, 8'h03, 8'h03);
    rd_chk(ADDR_BUFFER, 8'hff, 8'h5a);
    wr(ADDR_OWN, 8'hf2);
    `CHK("stretch", 1'b0, sclOe)
    i_mst.xfer({8'h11, 1'b1}, got);
    rd_chk(ADDR_BUFFER, 8'hff, 8'h11);
    i_mst.send_start();
    i_mst.xfer({8'hf3, 1'b1}, got);
    `CHK("ack", 1'b0, got[0])
    rd_chk(ADDR_STATUS, 8'h07, 8'h05);
    rd_chk(ADDR_BUFFER, 8'hff, 8'hf3);
    wr(ADDR_BUFFER, 8'hc5);
    wr(ADDR_CTRL, {4'h3, MODE_SLV10});
    i_mst.xfer(9'h1ff, got);
    `CHK("tx data", 8'hc5, got[8:1])
    `CHK("sda free", 1'b0, sdaOe)
    i_mst.send_stop();
  endtask : t_rx10
  task automatic t_master();
    int n;
    wr(ADDR_OWN, 8'h01);
    wr(ADDR_CTRL, {4'h2, MODE_MASTER});
    while (sclOe !== 1'b1) @(posedge sys_clk);
    n = 0;
    while (sclOe === 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("half period", 4, n)
  endtask : t_master
  task automatic end_sim();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    numErrors = 0;
    checkCount = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_rx7();
    t_reject();
    t_rx10();
    t_master();
    end_sim();
  end
  // the whole run needs under two thousand cycles; this leaves wide margin
  initial begin
    #300000;
    numErrors++;
    end_sim();
  end
endmodule : isa_i2c_slave_bench

//--- bench/isa_i2c_slave_properties.sv
`timescale 1ns/1ps
// ============================================================
// port checker, sees only the slave's pins
module isa_i2c_slave_properties
  import isa_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclIn,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        pinsOpenDrain,
  input wire logic        portIrq
);
  logic wrDone;
  logic wrIrq;
  logic wrRel;
  logic ctrlEnSh;
  logic ctrlMst;
  logic irqEnSh;
  assign wrDone = psel && penable && pready && pwrite;
  assign wrIrq  = wrDone && (paddr == ADDR_IRQ_FLAGS || paddr == ADDR_IRQ_EN);
  assign wrRel  = wrDone && (paddr == ADDR_OWN || paddr == ADDR_CTRL);
  // shadows follow writes so outputs can be tied to what software set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlEnSh <= 1'b0;
      ctrlMst  <= 1'b0;
      irqEnSh  <= 1'b0;
    end else if (wrDone) begin
      if (paddr == ADDR_CTRL) begin
        ctrlEnSh <= pwdata[CTL_EN];
        ctrlMst  <= (pwdata[3:0] == MODE_MASTER);
      end
      if (paddr == ADDR_IRQ_EN) begin
        irqEnSh <= pwdata[IRQ_PORT];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ============================================================
  // properties
  a_out_low: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin data not low");
  a_od_enable: assert property (pinsOpenDrain |-> ctrlEnSh || $past(ctrlEnSh, 2))
    else $error("open drain while disabled");
  a_drive_enable: assert property ((sdaOe || sclOe) |-> ctrlEnSh || $past(ctrlEnSh, 2))
    else $error("pin pulled while disabled");
  a_irq_enable: assert property (portIrq |-> irqEnSh || $past(irqEnSh, 2))
    else $error("irq while masked");
  a_irq_sticky: assert property ($fell(portIrq) |-> $past(wrIrq) || $past(wrIrq, 2))
    else $error("irq dropped without write");
  a_sda_change: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved while scl high");
  a_stretch_rise: assert property ($rose(sclOe) && !ctrlMst |-> !$past(sclIn))
    else $error("stretch began with scl high");
  a_stretch_free: assert property ($fell(sclOe) && !ctrlMst |-> $past(wrRel) || $past(wrRel, 2))
    else $error("stretch ended without write");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  c_ack: cover property ($rose(sdaOe) && !sclOe);
  c_stretch: cover property ($rose(sclOe) && !ctrlMst);
  c_irq: cover property ($rose(portIrq));
endmodule : isa_i2c_slave_properties

bind isa_i2c_slave isa_i2c_slave_properties i_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .pinsOpenDrain(pinsOpenDrain), .portIrq(portIrq)
);

//--- logic/isa_i2c_slave.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Function
// R1: enabled two-wire mode makes clock and data pins open-drain.
// R2: low four control bits pick 7-bit slave, 10-bit slave or master.
// R3: master clock is oscillator over four times (address register plus one).
// R4: port works only while the enable bit is set.
// R5: completed byte moves to the buffer and raises the port flag.
// R6: byte arriving while buffer full sets overflow and is dropped; overflow is set for data bytes only, a matched address byte is just dropped.
// R7: own-address register holds slave address, reloaded between 10-bit halves.
// R8: matched address or later data byte is acknowledged and buffered.
// R9: full or overflow withholds acknowledge and buffer load, still raises flag.
// R10: buffer read clears full; overflow clears only by software write.
// R11: after enabling, wait for start then shift eight bits.
// R12: data bits sampled on serial clock rising edge.
// R13: shift bits 7..1 compared with own address at eighth falling edge.
// R14: match loads buffer, sets full, acks, flags at ninth falling edge.
// R15: 10-bit header is 11110 A9 A8 with write direction.
// R16: first 10-bit byte sets flag, full, update-due and stretches clock.
// R17: second 10-bit byte does the same; reload releases clock.
// R18: after repeated start only the high byte must match, no update.
// R19: as slave-transmitter the device drives the data pin itself.
// R20: status shows start, stop, data/address, update-due and direction.
// R21: transmit bits change on falling clock edges.
// R22: master ack latched on ninth rising edge; nack ends transfer.
// R23: port flag sticks until cleared, requests only when enabled.
// R24: master must wait while the slave holds the clock low.
module isa_i2c_slave
  import isa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             pinsOpenDrain,
  output logic             portIrq
);
  // ==========================================================================
  // state
  isa_state_t  state_reg,     state_next;
  logic [7:0]  ctrl_reg,      ctrl_next;
  logic [7:0]  status_reg,    status_next;
  logic [7:0]  own_reg,       own_next;
  logic [7:0]  buf_reg,       buf_next;
  logic [7:0]  irqFlags_reg,  irqFlags_next;
  logic [7:0]  irqEn_reg,     irqEn_next;
  logic [7:0]  shift_reg,     shift_next;
  logic [3:0]  bitCnt_reg,    bitCnt_next;
  logic        addrPhase_reg, addrPhase_next;
  logic        tenLow_reg,    tenLow_next;
  logic        addr10_reg,    addr10_next;
  logic        sclPrev_reg,   sclPrev_next;
  logic        sdaPrev_reg,   sdaPrev_next;
  logic [8:0]  mstCnt_reg,    mstCnt_next;
  logic        mstScl_reg,    mstScl_next;
  logic [31:0] prdata_reg,    prdata_next;
  logic        pready_reg,    pready_next;
  logic        pslverr_reg,   pslverr_next;
  logic        sclOe_reg,     sclOe_next;
  logic        sdaOe_reg,     sdaOe_next;
  logic        odrain_reg,    odrain_next;
  logic        irq_reg,       irq_next;
  logic        enabled;
  logic        slaveMode;
  logic        masterMode;
  logic        sclRise;
  logic        sclFall;
  logic        startDet;
  logic        stopDet;
  logic        access;
  logic        doWrite;
  logic        doRead;
  logic        hit;
  logic [7:0]  rdByte;
  logic        accept;
  logic        match;
  logic        hiMatch;
  // ==========================================================================
  // next-state logic
  always_comb begin
    state_next     = state_reg;
    ctrl_next      = ctrl_reg;
    status_next    = status_reg;
    own_next       = own_reg;
    buf_next       = buf_reg;
    irqFlags_next  = irqFlags_reg;
    irqEn_next     = irqEn_reg;
    shift_next     = shift_reg;
    bitCnt_next    = bitCnt_reg;
    addrPhase_next = addrPhase_reg;
    tenLow_next    = tenLow_reg;
    addr10_next    = addr10_reg;
    mstCnt_next    = mstCnt_reg;
    mstScl_next    = mstScl_reg;
    sdaOe_next     = sdaOe_reg;
    sclPrev_next   = sclIn;
    sdaPrev_next   = sdaIn;
    enabled    = ctrl_reg[CTL_EN];
    slaveMode  = (ctrl_reg[3:0] == MODE_SLV7) || (ctrl_reg[3:0] == MODE_SLV10);  // R2
    masterMode = ctrl_reg[3:0] == MODE_MASTER;                                    // R2
    sclRise    = sclIn & ~sclPrev_reg;
    sclFall    = ~sclIn & sclPrev_reg;
    startDet   = sclIn & sclPrev_reg & ~sdaIn & sdaPrev_reg;
    stopDet    = sclIn & sclPrev_reg & sdaIn & ~sdaPrev_reg;
    accept     = ~status_reg[ST_BF] & ~ctrl_reg[CTL_OVF];
    hiMatch    = shift_reg[7:1] == own_reg[7:1];                                  // R13
    match      = 1'b0;
    // ==========================================================================
    // apb slave: one wait state, side effects at the completing edge
    access  = psel & penable;
    doWrite = access & pready_reg & pwrite;
    doRead  = access & pready_reg & ~pwrite;
    hit     = 1'b1;
    case (paddr)
      ADDR_IRQ_FLAGS: rdByte = irqFlags_reg;
      ADDR_IRQ_EN:    rdByte = irqEn_reg;
      ADDR_CTRL:      rdByte = ctrl_reg;
      ADDR_OWN:       rdByte = own_reg;
      ADDR_STATUS:    rdByte = status_reg;
      ADDR_BUFFER:    rdByte = buf_reg;
      default: begin
        rdByte = 8'h00;
        hit    = 1'b0;
      end
    endcase
    pready_next  = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~hit;
    prdata_next  = (access & ~pready_reg & ~pwrite) ? {24'h000000, rdByte} : 32'h00000000;
    if (doWrite) begin
      case (paddr)
        ADDR_IRQ_FLAGS: irqFlags_next = pwdata[7:0] & IRQ_IMPL_MASK;              // R23
        ADDR_IRQ_EN:    irqEn_next = pwdata[7:0] & IRQ_IMPL_MASK;
        ADDR_CTRL: begin
          ctrl_next = pwdata[7:0];
          ctrl_next[CTL_WRITE_COLLISION] = ctrl_reg[CTL_WRITE_COLLISION] & pwdata[CTL_WRITE_COLLISION];
          ctrl_next[CTL_OVF]  = ctrl_reg[CTL_OVF] & pwdata[CTL_OVF];              // R10
        end
        ADDR_OWN: begin
          own_next            = pwdata[7:0];                                      // R7
          status_next[ST_UA]  = 1'b0;                                             // R16 R17
        end
        ADDR_STATUS: status_next[ST_SMP:ST_CKE] = pwdata[ST_SMP:ST_CKE];
        ADDR_BUFFER: begin
          buf_next = pwdata[7:0];
          if (state_reg == ISA_TX || state_reg == ISA_TXACK) begin
            ctrl_next[CTL_WRITE_COLLISION] = 1'b1;
          end else begin
            shift_next = pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
    if (doRead && paddr == ADDR_BUFFER) begin
      status_next[ST_BF] = 1'b0;                                                  // R10
    end
    // ==========================================================================
    // master clock generator: period of 4 * (own + 1) core clocks
    if (enabled && masterMode) begin
      if (mstCnt_reg >= {own_reg, 1'b0} + 9'h001) begin                           // R3
        mstCnt_next = 9'h000;
        mstScl_next = ~mstScl_reg;
      end else begin
        mstCnt_next = mstCnt_reg + 9'h001;
      end
    end else begin
      mstCnt_next = 9'h000;
      mstScl_next = 1'b1;
    end
    // ==========================================================================
    // slave engine; hardware sets below override software clears above
    if (!enabled || !slaveMode) begin
      state_next  = ISA_IDLE;                                                     // R4
      sdaOe_next  = 1'b0;
      addr10_next = 1'b0;
      tenLow_next = 1'b0;
    end else if (startDet) begin
      state_next            = ISA_SHIFT;                                          // R11
      bitCnt_next           = 4'h0;
      addrPhase_next        = 1'b1;
      tenLow_next           = 1'b0;
      sdaOe_next            = 1'b0;
      status_next[ST_START] = 1'b1;                                               // R20
      status_next[ST_STOP]  = 1'b0;
    end else if (stopDet) begin
      state_next            = ISA_IDLE;
      sdaOe_next            = 1'b0;
      addr10_next           = 1'b0;
      status_next[ST_STOP]  = 1'b1;                                               // R20
      status_next[ST_START] = 1'b0;
    end else begin
      case (state_reg)
        ISA_SHIFT: begin
          if (sclRise) begin
            shift_next  = {shift_reg[6:0], sdaIn};                                // R12
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == BITS_BYTE) begin
            if (addrPhase_reg) begin
              if (ctrl_reg[3:0] == MODE_SLV7) begin
                match                = hiMatch;                                   // R13
                status_next[ST_RW]   = shift_reg[0];
                addrPhase_next       = ~hiMatch;
              end else if (!tenLow_reg) begin
                match = hiMatch && shift_reg[7:3] == TEN_BIT_HDR;                 // R15
                status_next[ST_RW] = shift_reg[0];
                if (match && addr10_reg && shift_reg[0]) begin
                  addrPhase_next = 1'b0;                                          // R18
                end else if (match) begin
                  tenLow_next        = 1'b1;
                  status_next[ST_UA] = 1'b1;                                      // R16
                end
              end else begin
                match              = shift_reg == own_reg;
                tenLow_next        = 1'b0;
                addr10_next        = match;
                addrPhase_next     = ~match;
                status_next[ST_UA] = match;                                       // R17
              end
              status_next[ST_DATA] = 1'b0;
            end else begin
              match                = 1'b1;
              status_next[ST_DATA] = 1'b1;
              if (status_reg[ST_BF]) begin
                ctrl_next[CTL_OVF] = 1'b1;                                        // R6
              end
            end
            if (match) begin
              state_next = ISA_ACK;
              sdaOe_next = accept;                                                // R8 R9
              if (accept) begin
                buf_next           = shift_reg;                                   // R5 R14
                status_next[ST_BF] = 1'b1;
              end
            end else begin
              state_next  = ISA_IDLE;
              tenLow_next = 1'b0;
            end
          end
        end
        ISA_ACK: begin
          if (sclFall) begin
            sdaOe_next              = 1'b0;
            irqFlags_next[IRQ_PORT] = 1'b1;                                       // R14 R9
            bitCnt_next             = 4'h0;
            if (!addrPhase_reg && status_reg[ST_RW] && status_next[ST_DATA] == 1'b0) begin
              state_next           = ISA_TXWAIT;
              ctrl_next[CTL_CKREL] = 1'b0;
            end else begin
              state_next = ISA_SHIFT;
            end
          end
        end
        ISA_TXWAIT: begin
          if (ctrl_next[CTL_CKREL]) begin
            sdaOe_next  = ~shift_next[7];                                         // R19 R21
            shift_next  = {shift_next[6:0], 1'b0};
            bitCnt_next = 4'h1;
            state_next  = ISA_TX;
          end
        end
        ISA_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == BITS_BYTE) begin
              sdaOe_next = 1'b0;
              state_next = ISA_TXACK;
            end else begin
              sdaOe_next  = ~shift_reg[7];                                        // R21
              shift_next  = {shift_reg[6:0], 1'b0};
              bitCnt_next = bitCnt_reg + 4'h1;
            end
          end
        end
        ISA_TXACK: begin
          if (sclRise && sdaIn) begin
            state_next = ISA_IDLE;                                                // R22
          end else if (sclFall) begin
            irqFlags_next[IRQ_PORT] = 1'b1;
            status_next[ST_DATA]    = 1'b1;
            ctrl_next[CTL_CKREL]    = 1'b0;
            state_next              = ISA_TXWAIT;
          end
        end
        default: ;
      endcase
    end
    // ==========================================================================
    // pins: both open-drain, only ever pulled low
    odrain_next = enabled & (slaveMode | masterMode);                             // R1
    sclOe_next  = (enabled & slaveMode & ((status_next[ST_UA] & (state_next != ISA_ACK))
                  | (state_next == ISA_TXWAIT & ~ctrl_next[CTL_CKREL])))          // R16 R24
                  | (enabled & masterMode & ~mstScl_next);
    irq_next    = irqFlags_next[IRQ_PORT] & irqEn_next[IRQ_PORT];                 // R23
  end
  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ISA_IDLE;
      ctrl_reg      <= RST_CTRL;
      status_reg    <= RST_STATUS;
      own_reg       <= RST_OWN;
      buf_reg       <= RST_BUFFER;
      irqFlags_reg  <= RST_IRQ_FLAGS;
      irqEn_reg     <= RST_IRQ_EN;
      shift_reg     <= 8'h00;
      bitCnt_reg    <= 4'h0;
      addrPhase_reg <= 1'b1;
      tenLow_reg    <= 1'b0;
      addr10_reg    <= 1'b0;
      sclPrev_reg   <= 1'b1;
      sdaPrev_reg   <= 1'b1;
      mstCnt_reg    <= 9'h000;
      mstScl_reg    <= 1'b1;
      prdata_reg    <= 32'h00000000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      sclOe_reg     <= 1'b0;
      sdaOe_reg     <= 1'b0;
      odrain_reg    <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      ctrl_reg      <= ctrl_next;
      status_reg    <= status_next;
      own_reg       <= own_next;
      buf_reg       <= buf_next;
      irqFlags_reg  <= irqFlags_next;
      irqEn_reg     <= irqEn_next;
      shift_reg     <= shift_next;
      bitCnt_reg    <= bitCnt_next;
      addrPhase_reg <= addrPhase_next;
      tenLow_reg    <= tenLow_next;
      addr10_reg    <= addr10_next;
      sclPrev_reg   <= sclPrev_next;
      sdaPrev_reg   <= sdaPrev_next;
      mstCnt_reg    <= mstCnt_next;
      mstScl_reg    <= mstScl_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      sclOe_reg     <= sclOe_next;
      sdaOe_reg     <= sdaOe_next;
      odrain_reg    <= odrain_next;
      irq_reg       <= irq_next;
    end
  end
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign sclOe         = sclOe_reg;
  assign sdaOe         = sdaOe_reg;
  assign sclOut        = ~odrain_reg & 1'b0;
  assign sdaOut        = ~odrain_reg & 1'b0;
  assign pinsOpenDrain = odrain_reg;
  assign portIrq       = irq_reg;
endmodule : isa_i2c_slave

//--- logic/isa_pkg.sv
package isa_pkg;

  // ==========================================================================
  // register indices (byte address = bank base + 4 * index)
  localparam logic [7:0]  IDX_IRQ_FLAGS  = 8'h10;
  localparam logic [7:0]  IDX_IRQ_EN     = 8'h11;
  localparam logic [7:0]  IDX_CTRL_FIRST = 8'h11;
  localparam logic [7:0]  IDX_OWN_ADDR   = 8'h12;
  localparam logic [7:0]  IDX_STATUS     = 8'h13;
  localparam logic [7:0]  IDX_BUFFER     = 8'h14;
  localparam logic [11:0] BASE_PORT      = 12'h000;
  localparam logic [11:0] BASE_IRQ       = 12'h100;
  localparam logic [11:0] ADDR_IRQ_FLAGS = BASE_IRQ + {2'h0, IDX_IRQ_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_EN    = BASE_IRQ + {2'h0, IDX_IRQ_EN, 2'h0};
  localparam logic [11:0] ADDR_CTRL      = BASE_PORT + {2'h0, IDX_CTRL_FIRST, 2'h0};
  localparam logic [11:0] ADDR_OWN       = BASE_PORT + {2'h0, IDX_OWN_ADDR, 2'h0};
  localparam logic [11:0] ADDR_STATUS    = BASE_PORT + {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_BUFFER    = BASE_PORT + {2'h0, IDX_BUFFER, 2'h0};

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0]  RST_IRQ_FLAGS  = 8'h02;
  localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
  localparam logic [7:0]  RST_CTRL       = 8'h00;
  localparam logic [7:0]  RST_STATUS     = 8'h00;
  localparam logic [7:0]  RST_OWN        = 8'h00;
  localparam logic [7:0]  RST_BUFFER     = 8'h00;
  localparam logic [7:0]  IRQ_IMPL_MASK  = 8'hef;

  // ==========================================================================
  // field positions
  localparam int CTL_WRITE_COLLISION   = 7;
  localparam int CTL_OVF    = 6;
  localparam int CTL_EN     = 5;
  localparam int CTL_CKREL  = 4;
  localparam int ST_SMP     = 7;
  localparam int ST_CKE     = 6;
  localparam int ST_DATA    = 5;
  localparam int ST_STOP    = 4;
  localparam int ST_START   = 3;
  localparam int ST_RW      = 2;
  localparam int ST_UA      = 1;
  localparam int ST_BF      = 0;
  localparam int IRQ_PORT   = 7;

  // ==========================================================================
  // modes and protocol constants
  localparam logic [3:0] MODE_SLV7   = 4'h6;
  localparam logic [3:0] MODE_SLV10  = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  typedef enum logic [2:0] {
    ISA_IDLE, ISA_SHIFT, ISA_ACK, ISA_TXWAIT, ISA_TX, ISA_TXACK
  } isa_state_t;

endpackage : isa_pkg
